// ### src/watchdog_timer_unit.v
// Watchdog timer unit: APB control/status, change window, modes, counter
// How it works
// - Counter advances on edges of the separate 128 kHz oscillator pin.
// - Restart instruction clears the counter; missing it leads to interrupt or reset.
// - Interrupt mode: expiry sets flag and requests interrupt only, usable for wake.
// - Reset mode: expiry gives one-cycle system reset, no interrupt.
// - Combined mode: first expiry interrupts, a later one resets.
// - Always-on fuse forces reset enable to 1, interrupt enable to 0.
// - Reset-enable clear and period change accepted only within four cycles.
// - Periods selectable from about 16 ms to about 8 s.
// - Control layout: flag7 irq6 psel3 at5 chg4 rst3 psel2..0; reset zero.
// - Timeout flag set on expiry while configured for interrupt.
// - Executing the watchdog vector clears the timeout flag.
// - Writing one to the flag clears it, zero leaves it.
// - Interrupt request needs global enable, irq enable and flag together.
// - Watchdog stays enabled after its own reset; software clears it later.
// - Reset-cause flag forces reset enable to one.
// - Change enable self-clears four clock cycles after being set.
// - Codes 0..9 give 2048 doubling to 1048576 oscillator cycles.
// - Vector in combined mode clears irq enable and flag.
//
// Register map
//   CTRL  at byte 0x00: control/status byte in bits 7:0, upper bits read zero
//   COUNT at byte 0x04: live counter value, read only, writes dropped
//   Any other address: access refused with pslverr, reads return zero
//
// Bus timing
//   Zero wait states, pready tied high
//   Writes land at the access edge
//   Read data captured at the setup edge, shown during the access cycle
//   A write just before a read is visible, since the read is captured at an edge after the write's access edge
//
// Change window
//   Opening write sets change-enable and always sets reset-enable
//   Change-enable reads one for four edges after the opening write
//   A second control write with change-enable zero may then clear
//   reset-enable and load a new period select
//   The opening write itself never loads the period select
//   Outside the window reset-enable can only be set, never cleared
//   Interrupt-enable is written freely at any time
//
// Modes, from the effective enables
//   Neither enable: counter held at zero, expiry impossible
//   Interrupt only: expiry sets the timeout flag
//   Reset only: expiry gives a one-cycle system reset pulse
//   Both: first expiry sets the flag; a second one with the flag
//   still set gives a reset; taking the vector drops interrupt-enable
//   Fuse programmed: behaves as reset only, enables read back forced
//
// Timeout flag
//   Set by expiry in a mode with interrupts
//   Cleared by the vector acknowledge or by writing one to bit 7
//   A set in the same cycle as a clear wins, so no expiry is lost
//
// Oscillator
//   Sampled as a slow input through two flip-flops, rising edges counted
//   It must run much slower than the core clock; an edge is seen
//   about three core cycles after it occurs on the pin
//   Period length is one oscillator period uncertain, as the phase of
//   the first edge after a restart is not known
//
// Reset cause
//   While the reset-cause flag is high, reset-enable is forced to one,
//   so a watchdog that has reset the system keeps running
//   Software must clear the cause flag before it can clear reset-enable
//
// Limitations
//   Reserved period codes are stored and read back but time as code 9
//   The fuse input is taken as static and is not synchronised
//   Reset-enable comes out of reset as zero
//   Shortening the period without a restart may expire at once, since the
//   counter is compared with greater-or-equal
//
// Parameters
//   BASE_SHIFT sets the shortest period as a power of two of ticks;
//   a small value shortens simulation runs
//   CNT_W must hold the longest period count
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"

module watchdog_timer_unit #(
    parameter BASE_SHIFT = `WD_BASE_SHIFT,
    parameter CNT_W      = `WD_CNT_W
) (
    // Clock and reset
    input  wire                 core_clk,
    input  wire                 rst,
    // APB slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [`WD_ADDR_W-1:0] paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output wire                 pready,
    output wire                 pslverr,
    // Watchdog oscillator pin
    input  wire                 osc_pin,
    // Core and system reset logic
    input  wire                 restart_cmd,
    input  wire                 global_irq_enable,
    input  wire                 irq_vector_ack,
    input  wire                 always_on_fuse,
    input  wire                 dog_reset_cause_flag,
    // Outputs to core and reset logic
    output wire                 irq_req,
    output reg                  sys_reset
);

    // Control/status fields
    reg             timeout_flag;
    reg             irq_enable_bit;
    reg             change_enable_bit;
    reg             reset_enable_bit;
    reg [3:0]       period_select;
    reg [2:0]       chg_cnt;

    reg             next_timeout_flag;
    reg             next_irq_enable_bit;
    reg             next_reset_enable_bit;
    reg [3:0]       next_period_select;

    wire            osc_tick;
    wire            expire;
    wire [CNT_W-1:0] count;
    wire            run;
    wire            eff_rst_en;
    wire            eff_irq_en;

    // Bus decode; zero wait states so pready is tied high
    wire access   = psel & penable;
    wire sel_ctrl = (paddr == `WD_OFF_CTRL);
    wire sel_cnt  = (paddr == `WD_OFF_COUNT);
    wire mapped   = sel_ctrl | sel_cnt;
    wire wr_ctrl  = access & pwrite & sel_ctrl;
    wire opening  = wr_ctrl & pwdata[`WD_BIT_CHG_EN] & pwdata[`WD_BIT_RST_EN];
    wire in_window = change_enable_bit & ~pwdata[`WD_BIT_CHG_EN];

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Effective mode bits as seen by the timer and by readback
    assign eff_rst_en = always_on_fuse | dog_reset_cause_flag | reset_enable_bit;
    assign eff_irq_en = ~always_on_fuse & irq_enable_bit;
    assign run        = eff_rst_en | eff_irq_en;

    // Interrupt request gating
    assign irq_req = global_irq_enable & eff_irq_en & timeout_flag;

    // Oscillator pin into core clock domain
    osc_edge_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .osc_pin  (osc_pin),
        .osc_rise (osc_tick)
    );

    // Time-out counter
    wdog_counter #(
        .BASE_SHIFT (BASE_SHIFT),
        .CNT_W      (CNT_W)
    ) u_counter (
        .core_clk      (core_clk),
        .rst           (rst),
        .osc_tick      (osc_tick),
        .run           (run),
        .restart       (restart_cmd),
        .period_select (period_select),
        .expire        (expire),
        .count         (count)
    );

    // Expiry action per mode
    wire irq_mode   = eff_irq_en & ~eff_rst_en;
    wire rst_mode   = eff_rst_en & ~eff_irq_en;
    wire comb_mode  = eff_irq_en & eff_rst_en;
    // Combined mode resets if the first interrupt was not serviced yet
    wire set_flag   = expire & (irq_mode | (comb_mode & ~timeout_flag));
    wire fire_reset = expire & (rst_mode | (comb_mode & timeout_flag));

    // Next values of the control fields
    always @* begin
        next_timeout_flag     = timeout_flag;
        next_irq_enable_bit   = irq_enable_bit;
        next_reset_enable_bit = reset_enable_bit;
        next_period_select    = period_select;

        // Flag: clear by vector or write of one; a same-cycle set wins
        if (irq_vector_ack) begin
            next_timeout_flag = 1'b0;
        end
        if (wr_ctrl && pwdata[`WD_BIT_TIMEOUT]) begin
            next_timeout_flag = 1'b0;
        end
        if (set_flag) begin
            next_timeout_flag = 1'b1;
        end

        // Interrupt enable: free write, dropped by vector in combined mode
        if (wr_ctrl) begin
            next_irq_enable_bit = pwdata[`WD_BIT_IRQ_EN];
        end
        if (irq_vector_ack && comb_mode) begin
            next_irq_enable_bit = 1'b0;
        end
        if (always_on_fuse) begin
            next_irq_enable_bit = 1'b0;
        end

        // Reset enable: set any time, cleared only in the open window
        if (wr_ctrl) begin
            if (pwdata[`WD_BIT_RST_EN]) begin
                next_reset_enable_bit = 1'b1;
            end else if (in_window) begin
                next_reset_enable_bit = 1'b0;
            end
        end
        if (always_on_fuse || dog_reset_cause_flag) begin
            next_reset_enable_bit = 1'b1;
        end

        // Period select changes only inside the window
        if (wr_ctrl && in_window) begin
            next_period_select = {pwdata[`WD_BIT_PSEL_MSB],
                                  pwdata[`WD_BIT_PSEL_HI:`WD_BIT_PSEL_LO]};
        end
    end

    // Field registers
    always @(posedge core_clk) begin
        if (rst) begin
            timeout_flag     <= 1'b0;
            irq_enable_bit   <= 1'b0;
            reset_enable_bit <= `WD_RST_RST_EN;
            period_select    <= `WD_RST_PERIOD;
        end else begin
            timeout_flag     <= next_timeout_flag;
            irq_enable_bit   <= next_irq_enable_bit;
            reset_enable_bit <= next_reset_enable_bit;
            period_select    <= next_period_select;
        end
    end

    // Change window: open on the opening write, shut four cycles later
    always @(posedge core_clk) begin
        if (rst) begin
            change_enable_bit <= 1'b0;
            chg_cnt           <= 3'h0;
        end else if (opening) begin
            change_enable_bit <= 1'b1;
            chg_cnt           <= `WD_CHG_LOAD;
        end else if (change_enable_bit) begin
            if (chg_cnt == 3'h0) begin
                change_enable_bit <= 1'b0;
            end else begin
                chg_cnt <= chg_cnt - 3'h1;
            end
        end
    end

    // One-cycle system reset pulse toward the reset logic
    always @(posedge core_clk) begin
        if (rst) begin
            sys_reset <= 1'b0;
        end else begin
            sys_reset <= fire_reset;
        end
    end

    // Read data captured in the setup phase, shown in the access phase
    always @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (sel_ctrl) begin
                prdata <= {24'h00_0000, timeout_flag, eff_irq_en, period_select[3],
                           change_enable_bit, eff_rst_en, period_select[2:0]};
            end else if (sel_cnt) begin
                prdata <= {{(32-CNT_W){1'b0}}, count};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule // watchdog_timer_unit

`default_nettype wire

// ### src/watchdog_consts.vh
// Register map, field positions and timing counts of the watchdog unit
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// Register byte offsets on the APB port
`define WD_ADDR_W          8
`define WD_OFF_CTRL        8'h00
`define WD_OFF_COUNT       8'h04

// Control/status field positions
`define WD_BIT_TIMEOUT     7
`define WD_BIT_IRQ_EN      6
`define WD_BIT_PSEL_MSB    5
`define WD_BIT_CHG_EN      4
`define WD_BIT_RST_EN      3
`define WD_BIT_PSEL_HI     2
`define WD_BIT_PSEL_LO     0

// Reset values of the control fields
`define WD_RST_PERIOD      4'h0
`define WD_RST_RST_EN      1'b0

// Change window length in core clock cycles, loaded as count minus one
`define WD_CHG_CYCLES      4
`define WD_CHG_LOAD        3'h3

// Time-out table: 2048 oscillator cycles at code 0, doubling per code
`define WD_OSC_KHZ         128
`define WD_BASE_SHIFT      11
`define WD_MAX_CODE        4'h9
`define WD_CNT_W           21

`endif

// ### src/osc_edge_sync.v
// Two-flop synchroniser with rising edge pulse for the oscillator pin
`timescale 1ns/1ps
`default_nettype none

module osc_edge_sync (
    // Clock and reset
    input  wire core_clk,
    input  wire rst,
    // Pin side
    input  wire osc_pin,
    // Core side
    output reg  osc_rise
);

    reg stage_a;
    reg stage_b;
    reg stage_c;

    // Only stage_b and stage_c are looked at; stage_a may be metastable
    always @(posedge core_clk) begin
        if (rst) begin
            stage_a  <= 1'b0;
            stage_b  <= 1'b0;
            stage_c  <= 1'b0;
            osc_rise <= 1'b0;
        end else begin
            stage_a  <= osc_pin;
            stage_b  <= stage_a;
            stage_c  <= stage_b;
            osc_rise <= stage_b & ~stage_c;
        end
    end

endmodule // osc_edge_sync

`default_nettype wire

// ### src/wdog_counter.v
// Oscillator cycle counter with selectable time-out and restart
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"

module wdog_counter #(
    parameter BASE_SHIFT = `WD_BASE_SHIFT,
    parameter CNT_W      = `WD_CNT_W
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             rst,
    // Control
    input  wire             osc_tick,
    input  wire             run,
    input  wire             restart,
    input  wire [3:0]       period_select,
    // Status
    output reg              expire,
    output reg  [CNT_W-1:0] count
);

    reg [3:0]       code;
    reg [CNT_W-1:0] limit;

    // Terminal count; reserved codes behave as the longest period
    always @* begin
        code  = (period_select > `WD_MAX_CODE) ? `WD_MAX_CODE : period_select;
        limit = ({{(CNT_W-1){1'b0}}, 1'b1} << (BASE_SHIFT + code)) - {{(CNT_W-1){1'b0}}, 1'b1};
    end

    // Counting; a shorter period takes effect at once, hence >= compare
    always @(posedge core_clk) begin
        if (rst || !run || restart) begin
            count  <= {CNT_W{1'b0}};
            expire <= 1'b0;
        end else if (osc_tick) begin
            if (count >= limit) begin
                count  <= {CNT_W{1'b0}};
                expire <= 1'b1;
            end else begin
                count  <= count + {{(CNT_W-1){1'b0}}, 1'b1};
                expire <= 1'b0;
            end
        end else begin
            expire <= 1'b0;
        end
    end

endmodule // wdog_counter

`default_nettype wire

// ### tb/wdog_monitor.sv
// Port-level assertions for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"
module wdog_monitor #(
    parameter BASE_SHIFT = 11,
    parameter CNT_W      = 21
) (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [`WD_ADDR_W-1:0] paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Core side
    input wire logic                  restart_cmd,
    input wire logic                  global_irq_enable,
    input wire logic                  irq_vector_ack,
    input wire logic                  always_on_fuse,
    input wire logic                  irq_req,
    input wire logic                  sys_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Register bus answers, and outputs quiet after reset
    a_bad_addr_err:
        assert property (psel && penable && paddr != 8'h00 && paddr != 8'h04 |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_good_addr_ok:
        assert property (psel && penable && paddr == 8'h04 |-> !pslverr && pready)
        else $error("mapped access refused");
    a_bad_rd_zero:
        assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($fell(rst) |-> !sys_reset && !irq_req)
        else $error("output active after reset");
    // Interrupt and reset outputs
    a_irq_needs_gie: assert property (irq_req |-> global_irq_enable)
        else $error("irq without global enable");
    a_fuse_no_irq: assert property (always_on_fuse |-> !irq_req)
        else $error("irq with fuse set");
    a_ack_drops_irq: assert property (irq_vector_ack |=> !irq_req)
        else $error("irq kept after vector");
    a_irq_held:
        assert property (irq_req && !irq_vector_ack && !(psel && penable && pwrite)
            |=> irq_req || !global_irq_enable) else $error("irq dropped alone");
    a_reset_pulse: assert property (sys_reset |=> !sys_reset)
        else $error("reset pulse too long");
    a_restart_quiet: assert property (restart_cmd |-> ##3 !sys_reset [*8])
        else $error("reset right after restart");
    // Main scenarios reached
    c_reset: cover property (sys_reset);
    c_vector: cover property (irq_vector_ack);
    c_refused: cover property (psel && penable && pslverr);
endmodule // wdog_monitor
`default_nettype wire

// ### tb/core_model.sv
// Core and system reset model: oscillator, vector taking, cause flag
`timescale 1ns/1ps
`default_nettype none
module core_model #(
    parameter OSC_HALF = 156
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // From the watchdog
    input  wire logic irq_req,
    input  wire logic sys_reset,
    // Bench controls
    input  wire logic ack_en,
    input  wire logic cause_clr,
    // To the watchdog
    output var  logic osc_pin,
    output var  logic irq_vector_ack,
    output var  logic dog_reset_cause_flag
);
    int div;
    // 128 kHz oscillator, held low with its divider cleared in reset
    always @(posedge core_clk) begin
        div <= (rst || div == OSC_HALF - 1) ? 0 : div + 1;
        osc_pin <= rst ? 1'h0 : osc_pin ^ (div == OSC_HALF - 1);
    end
    // Take the vector one cycle after the request, once per request
    always @(posedge core_clk) begin
        irq_vector_ack <= !rst && ack_en && irq_req && !irq_vector_ack;
    end
    // Cause flag set by a watchdog reset until software clears it
    always @(posedge core_clk) begin
        if (rst || cause_clr) dog_reset_cause_flag <= 1'h0;
        else if (sys_reset) dog_reset_cause_flag <= 1'h1;
    end
endmodule // core_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"
module testbench;
    localparam OSC_HALF = 156;
    logic        core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        restart_cmd = 1'h0, global_irq_enable = 1'h0, always_on_fuse = 1'h0;
    logic        ack_en = 1'h1, cause_clr = 1'h0, err, pready, pslverr, osc_pin;
    logic        irq_vector_ack, dog_reset_cause_flag, irq_req, sys_reset;
    integer      n_mismatch = 0, tests_run = 0, cyc = 0, ev, i, c;

    watchdog_timer_unit #(.BASE_SHIFT(2)) i_watchdog_timer_unit (.core_clk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_pin, .restart_cmd,
        .global_irq_enable, .irq_vector_ack, .always_on_fuse, .dog_reset_cause_flag, .irq_req,
        .sys_reset);
    core_model #(.OSC_HALF(OSC_HALF)) i_core_model (.core_clk, .rst, .irq_req, .sys_reset,
        .ack_en, .cause_clr, .osc_pin, .irq_vector_ack, .dog_reset_cause_flag);

    // 40 MHz clock and a hang guard
    always #12.5 core_clk = !core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            print_verdict;
        end
    end

    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Expiry must fall within one oscillator period of the nominal count
    function automatic logic [31:0] fits(input integer c, n);
        return {31'h0, n >= ((4 << c) - 1) * 2 * OSC_HALF - 10 && n <= (4 << c) * 2 * OSC_HALF + 10};
    endfunction
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] d);
        apb(1'h1, `WD_OFF_CTRL, {24'h0, d});
    endtask
    task automatic rdc(input logic [7:0] e);
        apb(1'h0, `WD_OFF_CTRL, 32'h0);
        chk("ctrl", rd, {24'h0, e});
    endtask
    task automatic win(input logic [7:0] d);
        wr(8'h18);
        wr(d);
    endtask
    task automatic kick;
        @(posedge core_clk);
        restart_cmd <= 1'h1;
        cause_clr <= 1'h1;
        @(posedge core_clk);
        restart_cmd <= 1'h0;
        cause_clr <= 1'h0;
    endtask
    task automatic cfg(input logic [7:0] d);
        kick;
        win(d);
    endtask
    task automatic ev_wait(input integer lim);
        ev = 0;
        for (i = 0; i < lim && ev == 0; i++) begin
            @(negedge core_clk);
            if (sys_reset === 1'h1) ev = 2;
            else if (irq_req === 1'h1) ev = 1;
        end
        // Back onto the rising edge so later stimulus is not launched mid-cycle
        @(posedge core_clk);
    endtask

    initial begin
        void'($urandom(32'hB2E6D675));
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        rdc(8'h00);
        apb(1'h0, 8'h08, 32'h0);
        chk("unmapped", {err, rd}, {1'h1, 32'h0});
        // Random periods, reserved codes included
        repeat (4) begin
            c = $urandom & 32'h27;
            win(c[7:0]);
            rdc(c[7:0]);
        end
        // Changes outside the window are ignored
        win(8'h05);
        wr(8'h01);
        rdc(8'h05);
        wr(8'h18);
        repeat (6) @(posedge core_clk);
        wr(8'h00);
        rdc(8'h0D);
        cfg(8'h00);
        ev_wait(3000);
        chk("stopped", ev, 0);
        apb(1'h0, `WD_OFF_COUNT, 32'h0);
        chk("count", rd, 32'h0);
        for (c = 0; c < 3; c++) begin
            cfg(8'h08 | c[7:0]);
            ev_wait(8000);
            chk("reset mode", ev, 2);
            chk("period", fits(c, i), 1);
        end
        win(8'h00);
        rdc(8'h08);
        cfg(8'h00);
        rdc(8'h00);
        cfg(8'h08);
        repeat (6) begin
            ev_wait(600);
            chk("restarted", ev, 0);
            kick;
        end
        global_irq_enable <= 1'h1;
        cfg(8'h40);
        ev_wait(3000);
        chk("irq mode", ev, 1);
        repeat (4) @(posedge core_clk);
        rdc(8'h40);
        global_irq_enable <= 1'h0;
        kick;
        ev_wait(1500);
        chk("masked", ev, 0);
        rdc(8'hC0);
        kick;
        wr(8'h40);
        rdc(8'hC0);
        wr(8'hC0);
        rdc(8'h40);
        global_irq_enable <= 1'h1;
        cfg(8'h48);
        ev_wait(3000);
        chk("first expiry", ev, 1);
        repeat (4) @(posedge core_clk);
        rdc(8'h08);
        ev_wait(3000);
        chk("second expiry", ev, 2);
        always_on_fuse <= 1'h1;
        cfg(8'h40);
        rdc(8'h08);
        ev_wait(3000);
        chk("fuse", ev, 2);
        // Reset in mid-run returns the fields to zero
        always_on_fuse <= 1'h0;
        rst <= 1'h1;
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        rdc(8'h00);
        print_verdict;
    end
endmodule // testbench
bind watchdog_timer_unit wdog_monitor #(.BASE_SHIFT(BASE_SHIFT), .CNT_W(CNT_W)) i_wdog_monitor (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .restart_cmd,
    .global_irq_enable, .irq_vector_ack, .always_on_fuse, .irq_req, .sys_reset);
`default_nettype wire
